/* rtl/thermal_cfg_pkg.sv */
// Constants shared by the thermal safety and monitor configuration slice
package thermal_cfg_pkg;
   // Register offsets on the byte-wide register port
   localparam logic [7:0] ZONE1_ABS_LIMIT_OFS = 8'h6A;
   localparam logic [7:0] ZONE2_ABS_LIMIT_OFS = 8'h6B;
   localparam logic [7:0] ZONE3_ABS_LIMIT_OFS = 8'h6C;
   localparam logic [7:0] XOR_TREE_CTRL_OFS = 8'h6F;
   localparam logic [7:0] VENDOR_TEST_A_OFS = 8'h79;
   localparam logic [7:0] VENDOR_TEST_B_OFS = 8'h7A;
   localparam logic [7:0] VENDOR_TEST_C_OFS = 8'h7B;
   localparam logic [7:0] POWER_MON_CTRL_OFS = 8'h7C;

   // Reset values
   localparam logic [7:0] ABS_LIMIT_RST = 8'h64;
   localparam logic [7:0] XOR_TREE_CTRL_RST = 8'h00;
   localparam logic [7:0] VENDOR_TEST_RST = 8'h00;
   localparam logic [7:0] POWER_MON_CTRL_RST = 8'h40;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Special values
   localparam logic [7:0] ABS_LIMIT_DISABLE = 8'h80;
   localparam logic [7:0] FULL_DUTY = 8'hFF;

   // Field positions
   localparam int XOR_ENABLE_BIT = 0;
   localparam int LOW_POWER_BIT = 0;
   localparam int MONITOR_CYCLE_BIT = 1;
   localparam int IRQ_PIN_EN_BIT = 2;
   localparam int AVG_LSB = 5;
   localparam int AVG_MSB = 7;

   // Sizes
   localparam int NUM_ZONES = 3;
   localparam int NUM_FANS = 3;
   localparam int NUM_MEAS = 6;
   localparam int NUM_REMOTE = 2;
   localparam int SAMPLE_W = 10;
   localparam int SHIFT_W = 3;
   localparam int MAX_SHIFT = 7;
   localparam int ACC_W = SAMPLE_W + MAX_SHIFT;
   localparam int CNT_W = MAX_SHIFT;

   // Averaging depths as log2 of the count
   localparam logic [SHIFT_W-1:0] AVG_LOG2_1 = 3'h0;
   localparam logic [SHIFT_W-1:0] AVG_LOG2_8 = 3'h3;
   localparam logic [SHIFT_W-1:0] AVG_LOG2_16 = 3'h4;
   localparam logic [SHIFT_W-1:0] AVG_LOG2_32 = 3'h5;
   localparam logic [SHIFT_W-1:0] AVG_LOG2_128 = 3'h7;

   // Per-fan control mode, as reported by the fan configuration logic
   typedef enum logic [1:0] {
      FAN_AUTO = 2'b00,
      FAN_MANUAL = 2'b01,
      FAN_DISABLED = 2'b10
   } fan_mode_t;

   // Averager state
   typedef enum logic [1:0] {
      AVG_IDLE = 2'b01,
      AVG_ACCUM = 2'b10
   } avg_state_t;
endpackage

/* rtl/measurement_averager.sv */
// Accumulates a power-of-two number of samples and publishes their mean
`timescale 1ns/1ps
module measurement_averager
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [SHIFT_W-1:0] avg_log2,
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample,
   output logic [SAMPLE_W-1:0] reading,
   output logic reading_valid
);
   avg_state_t state_r;
   avg_state_t state_nxt;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [SHIFT_W-1:0] depth_r;
   logic [SAMPLE_W-1:0] reading_r;
   logic reading_valid_r;

   wire logic [CNT_W-1:0] last_cnt = CNT_W'((1 << depth_r) - 1);
   wire logic [ACC_W-1:0] acc_sum = acc_r + ACC_W'(sample);
   wire logic depth_change = (avg_log2 != depth_r);
   wire logic last_sample = sample_valid && (cnt_r == last_cnt);
   wire logic [ACC_W-1:0] mean = acc_sum >> depth_r;

   // A depth change restarts the run so no mean mixes two depths
   always_comb begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      cnt_nxt = cnt_r;
      case (state_r)
         AVG_IDLE: begin
            acc_nxt = '0;
            cnt_nxt = '0;
            state_nxt = AVG_ACCUM;
         end
         AVG_ACCUM: begin
            if (depth_change) begin
               state_nxt = AVG_IDLE;
            end else if (last_sample) begin
               acc_nxt = '0;
               cnt_nxt = '0;
            end else if (sample_valid) begin
               acc_nxt = acc_sum;
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = AVG_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= AVG_IDLE;
         acc_r <= '0;
         cnt_r <= '0;
         depth_r <= AVG_LOG2_16;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
         depth_r <= avg_log2;
      end
   end

   // Reading updates only after the full count of samples
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reading_r <= '0;
         reading_valid_r <= 1'b0;
      end else begin
         reading_valid_r <= (state_r == AVG_ACCUM) && !depth_change && last_sample;
         if ((state_r == AVG_ACCUM) && !depth_change && last_sample) begin
            reading_r <= mean[SAMPLE_W-1:0];
         end
      end
   end

   assign reading = reading_r;
   assign reading_valid = reading_valid_r;
endmodule

/* rtl/thermal_safety_cfg.sv */
// Thermal safety override, XOR test tree and monitor configuration registers
`timescale 1ns/1ps
module thermal_safety_cfg
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic lock_in,
   input wire logic [7:0] zone_temp_0,
   input wire logic [7:0] zone_temp_1,
   input wire logic [7:0] zone_temp_2,
   input wire logic [1:0] fan_mode_0,
   input wire logic [1:0] fan_mode_1,
   input wire logic [1:0] fan_mode_2,
   input wire logic [7:0] fan_duty_in_0,
   input wire logic [7:0] fan_duty_in_1,
   input wire logic [7:0] fan_duty_in_2,
   output logic [7:0] fan_duty_out_0,
   output logic [7:0] fan_duty_out_1,
   output logic [7:0] fan_duty_out_2,
   output logic safety_override,
   output logic [2:0] zone_over_limit,
   input wire logic [4:0] voltage_id_in,
   input wire logic [3:0] fan_speed_in,
   input wire logic [1:0] fan_drive_out,
   output logic xor_tree_enable,
   output logic xor_tree_out,
   output logic low_power_select,
   output logic monitor_cycle_select,
   output logic irq_pin_enable,
   output logic [2:0] averaging_depth,
   input wire logic [NUM_MEAS-1:0] sample_valid,
   input wire logic [NUM_MEAS*SAMPLE_W-1:0] sample_data,
   output logic [NUM_MEAS*SAMPLE_W-1:0] reading_data,
   output logic [NUM_MEAS-1:0] reading_update
);
   // Averaging decode, MSB has priority; remote diodes differ in low codes
   function automatic logic [SHIFT_W-1:0] avg_decode(input logic [2:0] field, input logic remote);
      logic [SHIFT_W-1:0] res;
      res = AVG_LOG2_16;
      if (field[2]) begin
         res = AVG_LOG2_32;
      end else if (field[1]) begin
         res = AVG_LOG2_16;
      end else if (field[0]) begin
         res = remote ? AVG_LOG2_16 : AVG_LOG2_1;
      end else begin
         res = remote ? AVG_LOG2_128 : AVG_LOG2_8;
      end
      return res;
   endfunction

   // Register storage
   logic [7:0] abs_limit_r [NUM_ZONES];
   logic [7:0] xor_ctrl_r;
   logic [7:0] vendor_a_r;
   logic [7:0] vendor_c_r;
   logic [7:0] power_mon_r;
   logic [7:0] rdata_r;
   logic hit_r;
   logic [7:0] duty_out_r [NUM_FANS];
   logic override_r;
   logic [NUM_ZONES-1:0] over_r;
   logic xor_out_r;

   // Address decode
   wire logic sel_zone1 = (reg_addr == ZONE1_ABS_LIMIT_OFS);
   wire logic sel_zone2 = (reg_addr == ZONE2_ABS_LIMIT_OFS);
   wire logic sel_zone3 = (reg_addr == ZONE3_ABS_LIMIT_OFS);
   wire logic sel_xor = (reg_addr == XOR_TREE_CTRL_OFS);
   wire logic sel_va = (reg_addr == VENDOR_TEST_A_OFS);
   wire logic sel_vb = (reg_addr == VENDOR_TEST_B_OFS);
   wire logic sel_vc = (reg_addr == VENDOR_TEST_C_OFS);
   wire logic sel_pm = (reg_addr == POWER_MON_CTRL_OFS);
   wire logic [NUM_ZONES-1:0] sel_zone = {sel_zone3, sel_zone2, sel_zone1};
   wire logic sel_any = |{sel_zone, sel_xor, sel_va, sel_vb, sel_vc, sel_pm};

   // Once locked, writes are silently dropped
   wire logic wr_ok = reg_wr && !lock_in;

   // Register writes
   genvar z;
   generate
      for (z = 0; z < NUM_ZONES; z++) begin : g_limit
         always_ff @(posedge core_clk) begin
            if (rst) begin
               abs_limit_r[z] <= ABS_LIMIT_RST;
            end else if (wr_ok && sel_zone[z]) begin
               abs_limit_r[z] <= reg_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst) begin
         xor_ctrl_r <= XOR_TREE_CTRL_RST;
      end else if (wr_ok && sel_xor) begin
         xor_ctrl_r <= {7'h00, reg_wdata[XOR_ENABLE_BIT]};
      end
   end

   // Vendor test cells only store; they steer nothing here
   always_ff @(posedge core_clk) begin
      if (rst) begin
         vendor_a_r <= VENDOR_TEST_RST;
         vendor_c_r <= VENDOR_TEST_RST;
      end else begin
         if (wr_ok && sel_va) begin
            vendor_a_r <= reg_wdata;
         end
         if (wr_ok && sel_vc) begin
            vendor_c_r <= reg_wdata;
         end
      end
   end

   // Bits 3 and 4 are kept as plain storage
   always_ff @(posedge core_clk) begin
      if (rst) begin
         power_mon_r <= POWER_MON_CTRL_RST;
      end else if (wr_ok && sel_pm) begin
         power_mon_r <= reg_wdata;
      end
   end

   // Read path; vendor B is read-only and reads its reset value
   wire logic [7:0] zone_rd = sel_zone1 ? abs_limit_r[0] :
                              sel_zone2 ? abs_limit_r[1] : abs_limit_r[2];
   wire logic [7:0] rd_mux = (|sel_zone) ? zone_rd :
                             sel_xor ? xor_ctrl_r :
                             sel_va ? vendor_a_r :
                             sel_vb ? VENDOR_TEST_RST :
                             sel_vc ? vendor_c_r :
                             sel_pm ? power_mon_r : UNMAPPED_READ;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r <= UNMAPPED_READ;
         hit_r <= 1'b0;
      end else if (reg_rd) begin
         rdata_r <= rd_mux;
         hit_r <= sel_any;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_hit = hit_r;

   // Safety override
   wire logic [7:0] temp_in [NUM_ZONES];
   assign temp_in[0] = zone_temp_0;
   assign temp_in[1] = zone_temp_1;
   assign temp_in[2] = zone_temp_2;

   wire logic [NUM_ZONES-1:0] zone_exceeds;
   generate
      for (z = 0; z < NUM_ZONES; z++) begin : g_cmp
         // Every zone counts, associated with a fan or not
         assign zone_exceeds[z] = (abs_limit_r[z] != ABS_LIMIT_DISABLE) &&
                                  ($signed(temp_in[z]) > $signed(abs_limit_r[z]));
      end
   endgenerate

   wire fan_mode_t mode [NUM_FANS];
   wire logic [7:0] duty_in [NUM_FANS];
   assign mode[0] = fan_mode_t'(fan_mode_0);
   assign mode[1] = fan_mode_t'(fan_mode_1);
   assign mode[2] = fan_mode_t'(fan_mode_2);
   assign duty_in[0] = fan_duty_in_0;
   assign duty_in[1] = fan_duty_in_1;
   assign duty_in[2] = fan_duty_in_2;

   wire logic any_auto = (mode[0] == FAN_AUTO) || (mode[1] == FAN_AUTO) || (mode[2] == FAN_AUTO);
   // Level compare, so the override drops as soon as all zones cool
   wire logic override_nxt = any_auto && (|zone_exceeds);

   genvar f;
   generate
      for (f = 0; f < NUM_FANS; f++) begin : g_fan
         // Manual fans are forced too; disabled ones keep their own duty
         wire logic force_full = override_nxt && (mode[f] != FAN_DISABLED);
         always_ff @(posedge core_clk) begin
            if (rst) begin
               duty_out_r[f] <= 8'h00;
            end else begin
               duty_out_r[f] <= force_full ? FULL_DUTY : duty_in[f];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (rst) begin
         override_r <= 1'b0;
         over_r <= '0;
      end else begin
         override_r <= override_nxt;
         over_r <= zone_exceeds;
      end
   end

   assign fan_duty_out_0 = duty_out_r[0];
   assign fan_duty_out_1 = duty_out_r[1];
   assign fan_duty_out_2 = duty_out_r[2];
   assign safety_override = override_r;
   assign zone_over_limit = over_r;

   // XOR tree; serial bus pins deliberately excluded
   wire logic xor_parity = ^{voltage_id_in, fan_speed_in, fan_drive_out};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         xor_out_r <= 1'b0;
      end else begin
         xor_out_r <= xor_ctrl_r[XOR_ENABLE_BIT] & xor_parity;
      end
   end

   assign xor_tree_enable = xor_ctrl_r[XOR_ENABLE_BIT];
   assign xor_tree_out = xor_out_r;

   // Mode outputs
   assign low_power_select = power_mon_r[LOW_POWER_BIT];
   assign monitor_cycle_select = power_mon_r[MONITOR_CYCLE_BIT];
   assign irq_pin_enable = power_mon_r[IRQ_PIN_EN_BIT];
   assign averaging_depth = power_mon_r[AVG_MSB:AVG_LSB];

   // Averaging; the first two measurements are the remote diodes
   wire logic [SHIFT_W-1:0] log2_remote = avg_decode(averaging_depth, 1'b1);
   wire logic [SHIFT_W-1:0] log2_local = avg_decode(averaging_depth, 1'b0);

   genvar m;
   generate
      for (m = 0; m < NUM_MEAS; m++) begin : g_avg
         measurement_averager u_avg (
            .core_clk(core_clk),
            .rst(rst),
            .avg_log2((m < NUM_REMOTE) ? log2_remote : log2_local),
            .sample_valid(sample_valid[m]),
            .sample(sample_data[m*SAMPLE_W +: SAMPLE_W]),
            .reading(reading_data[m*SAMPLE_W +: SAMPLE_W]),
            .reading_valid(reading_update[m])
         );
      end
   endgenerate
endmodule

/* verification/host_model.sv */
// Host-side register master issuing single-byte reads and writes
`timescale 1ns/1ps
module host_model
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      // Vendor test space is never written; it can upset the part
      if (a inside {VENDOR_TEST_A_OFS, VENDOR_TEST_B_OFS, VENDOR_TEST_C_OFS}) return;
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= (a == POWER_MON_CTRL_OFS) ? (d & 8'hE7) : d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

/* verification/thermal_cfg_checker_sva.sv */
// Port-level assertions for the thermal configuration slice
`timescale 1ns/1ps
module thermal_cfg_checker
   import thermal_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic lock_in,
   input wire logic [1:0] fan_mode_0,
   input wire logic [1:0] fan_mode_1,
   input wire logic [1:0] fan_mode_2,
   input wire logic [7:0] fan_duty_in_0,
   input wire logic [7:0] fan_duty_out_0,
   input wire logic [7:0] fan_duty_out_1,
   input wire logic safety_override,
   input wire logic [2:0] zone_over_limit,
   input wire logic [4:0] voltage_id_in,
   input wire logic [3:0] fan_speed_in,
   input wire logic [1:0] fan_drive_out,
   input wire logic xor_tree_enable,
   input wire logic xor_tree_out,
   input wire logic low_power_select,
   input wire logic monitor_cycle_select,
   input wire logic irq_pin_enable,
   input wire logic [2:0] averaging_depth,
   input wire logic [5:0] sample_valid,
   input wire logic [59:0] sample_data,
   input wire logic [59:0] reading_data,
   input wire logic [5:0] reading_update
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic mapped = reg_addr inside {8'h6A, 8'h6B, 8'h6C, 8'h6F, 8'h79, 8'h7A, 8'h7B, 8'h7C};
   wire logic auto_any = (fan_mode_0 == FAN_AUTO) || (fan_mode_1 == FAN_AUTO) || (fan_mode_2 == FAN_AUTO);
   wire logic [3:0] cfg_bits = {averaging_depth, irq_pin_enable};
   sequence s_cfg_wr;
      !lock_in && reg_wr && reg_addr == POWER_MON_CTRL_OFS;
   endsequence
   sequence s_depth1;
      averaging_depth == 3'b001 [*4] ##0 sample_valid[2];
   endsequence
   property p_hit;
      reg_rd |=> reg_hit == $past(mapped) && ($past(mapped) || reg_rdata == 8'h00);
   endproperty
   property p_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   property p_lock;
      lock_in && reg_wr |=> $stable({cfg_bits, monitor_cycle_select, low_power_select, xor_tree_enable});
   endproperty
   property p_cfg;
      s_cfg_wr |=> averaging_depth == $past(reg_wdata[7:5]) && irq_pin_enable == $past(reg_wdata[2])
         && monitor_cycle_select == $past(reg_wdata[1]) && low_power_select == $past(reg_wdata[0]);
   endproperty
   property p_xen;
      !lock_in && reg_wr && reg_addr == XOR_TREE_CTRL_OFS |=> xor_tree_enable == $past(reg_wdata[0]);
   endproperty
   property p_override;
      safety_override == ((|zone_over_limit) && $past(auto_any));
   endproperty
   property p_full;
      safety_override && $past(fan_mode_1) != FAN_DISABLED |-> fan_duty_out_1 == FULL_DUTY;
   endproperty
   property p_release;
      !safety_override && !$past(rst) |-> fan_duty_out_0 == $past(fan_duty_in_0);
   endproperty
   property p_xor;
      !$past(rst) |-> xor_tree_out == ($past(xor_tree_enable) && $past(^{voltage_id_in, fan_speed_in, fan_drive_out}));
   endproperty
   property p_avg1;
      s_depth1 |=> reading_update[2] && reading_data[29:20] == $past(sample_data[29:20]);
   endproperty
   a_hit: assert property (p_hit) else $error("read hit or unmapped data wrong");
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   a_lock: assert property (p_lock) else $error("locked write changed a register");
   a_cfg: assert property (p_cfg) else $error("special function fields wrong");
   a_xen: assert property (p_xen) else $error("xor enable not stored");
   a_override: assert property (p_override) else $error("override level wrong");
   a_full: assert property (p_full) else $error("non-disabled fan not at full duty");
   a_release: assert property (p_release) else $error("duty not passed through");
   a_xor: assert property (p_xor) else $error("xor tree output wrong");
   a_avg1: assert property (p_avg1) else $error("single-sample reading wrong");
endmodule
bind thermal_safety_cfg thermal_cfg_checker thermal_cfg_checker_i (.*);

/* verification/tb_top.sv */
// Self-checking bench for the thermal configuration slice
`timescale 1ns/1ps
module tb_top;
   import thermal_cfg_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic lock_in = 1'b0;
   logic probe = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_duty_out_0, fan_duty_out_1, fan_duty_out_2;
   logic reg_wr, reg_rd, reg_hit, safety_override, xor_tree_enable, xor_tree_out;
   logic low_power_select, monitor_cycle_select, irq_pin_enable;
   logic [2:0] zone_over_limit, averaging_depth;
   logic [7:0] zone_temp_0 = 8'h00, zone_temp_1 = 8'h00, zone_temp_2 = 8'h00;
   logic [1:0] fan_mode_0 = FAN_AUTO, fan_mode_1 = FAN_MANUAL, fan_mode_2 = FAN_DISABLED;
   logic [7:0] fan_duty_in_0 = 8'h11, fan_duty_in_1 = 8'h22, fan_duty_in_2 = 8'h33;
   logic [4:0] voltage_id_in = 5'h00;
   logic [3:0] fan_speed_in = 4'h0;
   logic [1:0] fan_drive_out = 2'h0;
   logic [5:0] sample_valid = 6'h00, reading_update;
   logic [59:0] sample_data = '0, reading_data;
   logic [24:0] expq[$];
   int error_cnt = 0;
   int samples_checked = 0;
   thermal_safety_cfg thermal_safety_cfg_i (.*);
   host_model host_model_i (.*);
   initial forever #2 core_clk = ~core_clk;
   task automatic check(string nm, logic [24:0] seen, logic [24:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Oldest note matches the oldest result; drivers never overlap
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d) check("reg_rdata", {17'h0, reg_rdata}, expq.pop_front());
      if (probe) check("fan_outputs", {safety_override, fan_duty_out_2, fan_duty_out_1, fan_duty_out_0}, expq.pop_front());
      if (reading_update[2]) check("reading", {15'h0, reading_data[29:20]}, expq.pop_front());
   end
   task automatic rd_chk(logic [7:0] a, logic [7:0] e);
      expq.push_back({17'h0, e});
      host_model_i.rd(a);
   endtask
   task automatic ov(logic [23:0] t, logic [1:0] m, logic trip);
      @(posedge core_clk);
      {zone_temp_2, zone_temp_1, zone_temp_0} <= t;
      fan_mode_0 <= m;
      @(posedge core_clk);
      expq.push_back(trip ? 25'h133_FFFF : 25'h033_2211);
      probe <= 1'b1;
      @(posedge core_clk);
      probe <= 1'b0;
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] v;
      logic [9:0] s;
      logic [7:0] ofs [9] = '{8'h6A, 8'h6B, 8'h6C, 8'h6F, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h70};
      logic [7:0] rv [9] = '{8'h64, 8'h64, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
      logic [7:0] ev [8] = '{8'h80, 8'h10, 8'h7F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h27};
      void'($urandom(32'hb725));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) rd_chk(ofs[i], rv[i]);
      for (int i = 0; i < 5; i++) begin
         v = 8'($urandom);
         host_model_i.wr(ofs[i == 4 ? 7 : i], v);
         rd_chk(ofs[i == 4 ? 7 : i], i == 4 ? (v & 8'hE7) : (i == 3 ? {7'h0, v[0]} : v));
      end
      for (int a = 0; a < 8; a++) host_model_i.wr(8'h7C, {a[2:0], 5'h07});
      for (int i = 0; i < 8; i++) host_model_i.wr(ofs[i], ev[i]);
      @(posedge core_clk) lock_in <= 1'b1;
      for (int i = 0; i < 8; i++) host_model_i.wr(ofs[i], 8'h5A);
      for (int i = 0; i < 8; i++) rd_chk(ofs[i], ev[i]);
      ov(24'h00_117F, FAN_AUTO, 1'b1);
      ov(24'h7F_107F, FAN_AUTO, 1'b0);
      ov(24'h00_F000, FAN_AUTO, 1'b0);
      ov(24'h00_1100, FAN_MANUAL, 1'b0);
      repeat (8) @(posedge core_clk) {voltage_id_in, fan_speed_in, fan_drive_out} <= 11'($urandom);
      s = 10'($urandom);
      @(posedge core_clk);
      expq.push_back({15'h0, s});
      sample_data[29:20] <= s;
      sample_valid[2] <= 1'b1;
      @(posedge core_clk) sample_valid[2] <= 1'b0;
      repeat (4) @(posedge core_clk);
      wrap_up;
   end
   // Whole sequence is about 123 cycles
   initial begin
      #20000;
      error_cnt++;
      wrap_up;
   end
endmodule
